/* design/flash_defs.svh */
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH

// Opcodes.
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_VOLATILE_ENABLE 8'h50
`define OP_STATUS_READ_1 8'h05
`define OP_STATUS_READ_2 8'h35
`define OP_STATUS_READ_3 8'h15
`define OP_STATUS_WRITE_1 8'h01
`define OP_STATUS_WRITE_2 8'h31
`define OP_STATUS_WRITE_3 8'h11
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_DUAL_OUT_READ 8'h3b
`define OP_QUAD_OUT_READ 8'h6b
`define OP_QUAD_IO_READ 8'heb
`define OP_QUAD_WORD_READ 8'he7
`define OP_SET_WRAP 8'h77

// Status register field positions, reset value and write mask.
`define SR_WIP 0
`define SR_WEL 1
`define SR_STATUS_PROTECT_LOWER 7
`define SR_QE 9
`define SR_RESET 24'h000000
`define SR_WRITE_MASK 24'h607ffc

// Security register 3 address bytes.
`define SEC3_UPPER 8'h00
`define SEC3_MIDDLE 8'h30

// Continuous read mode arm value of mode bits 5:4.
`define CONT_MODE_ARM 2'h2

// Wrap bits {w6,w5,w4}; w4 high means wrap is off.
`define WRAP_RESET 3'h1
`define WRAP_SLOT 5'h2

// Phase lengths in serial clocks.
`define OPCODE_CLKS 5'h08
`define ADDR_CLKS_SINGLE 5'h18
`define ADDR_CLKS_QUAD 5'h06
`define MODE_CLKS_QUAD 5'h02
`define DUMMY_CLKS_BYTE 5'h08
`define DUMMY_CLKS_QIO 5'h04
`define DUMMY_CLKS_QWORD 5'h02
`define DATA_IN_CLKS 5'h08
`define WRAP_CLKS 5'h08

// Timing.
`define REF_CLK_HZ 20000000
`define STATUS_WRITE_CYCLE_TIME_US 10000

`endif

/* design/flash_pkg.sv */
package flash_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_OPCODE = 4'h1,
		ST_ADDR = 4'h2,
		ST_MODE = 4'h3,
		ST_DUMMY = 4'h4,
		ST_DATA_OUT = 4'h5,
		ST_DATA_IN = 4'h6,
		ST_WRAP = 4'h7,
		ST_END = 4'h8,
		ST_IGNORE = 4'h9
	} state_t;

	typedef enum logic [1:0] {
		LANE_1 = 2'h0,
		LANE_2 = 2'h1,
		LANE_4 = 2'h2
	} lane_mode_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic [3:0] io;
	} pin_bus_t;

endpackage

/* design/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync import flash_pkg::*; #(
	parameter int W = 6,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Asynchronous inputs.
	input wire logic [W-1:0] async_in,
	// Synchronised levels and edge pulses.
	output logic [W-1:0] level,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	logic [W-1:0] meta;
	logic [W-1:0] prev;

	// The first stage feeds only the second one; edges come from later stages.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= INIT;
			level <= INIT;
			prev <= INIT;
			rise <= '0;
			fall <= '0;
		end else begin
			meta <= async_in;
			level <= meta;
			prev <= level;
			rise <= level & ~prev;
			fall <= ~level & prev;
		end
	end

endmodule

/* design/flash_cmd_core.sv */
`timescale 1ns/1ps
`include "flash_defs.svh"
// Notes on behaviour
// - Dual output: lane 1 carries bits 7,5,3,1; lane 0 bits 6,4,2,0.
// - Quad output: lanes 3..0 carry high nibble first, then low nibble.
// - Quad I/O read: four idle clocks after mode, then quad data.
// - Quad word read: address bit 0 zero, only two idle clocks before data.
// - Security register 3 sits at upper byte 00h, middle byte 30h.
// - Wrap bits ride lanes 0 to 2 in the seventh nibble clock.
// - Opcode 06h alone in a frame sets the write enable latch.
// - Latch clears on 04h, reset, and completion of any write cycle.
// - Opcodes 05h, 35h, 15h return status bytes 1, 2, 3.
// - Status reads work while busy and repeat while clocked.
// - Status writes 01h, 31h, 11h need the latch set first, or a 50h just before them.
// - Status bits 23, 20-15, 1 and 0 never change by a status write.
// - Status write runs only if select rises right after eight data bits.
// - Select rise starts timed cycle; busy flag high, then latch cleared.
// - Protect bits writable; hardware protected mode blocks status writes.
// - Opcode 50h lets the next status write touch only volatile bits.
// - Opcode 03h: 24-bit address, then data on falling edges, incrementing.
// - Reads are refused while a write or erase cycle is running.
// - Opcode 0Bh: address plus dummy byte, then incrementing single data.
// - Opcode 3Bh: address plus dummy byte, then two bits per clock.
// - Opcode 6Bh: address plus dummy byte, then four bits per clock.
// - Quad I/O reads need the quad enable bit set.
// - Mode bits 5:4 of 10b let the next quad read skip its opcode.
module flash_cmd_core import flash_pkg::*; #(
	parameter int STATUS_WRITE_CYCLES = `STATUS_WRITE_CYCLE_TIME_US * (`REF_CLK_HZ / 1000000)
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial pins.
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	// Memory array read port, data valid one cycle after the address.
	output logic [23:0] mem_addr,
	output logic mem_sec3,
	input wire logic [7:0] mem_rdata,
	// Program and erase engine.
	input wire logic ext_busy,
	input wire logic ext_done,
	// Status.
	output logic [23:0] status_out,
	output logic [23:0] status_nv
);

	pin_bus_t pin_lv;
	pin_bus_t pin_rise;
	pin_bus_t pin_fall;
	state_t state;
	lane_mode_t lanes;
	logic [7:0] opcode;
	logic [4:0] clk_left;
	logic [23:0] shift_in;
	logic [23:0] addr;
	logic [7:0] wsr_data;
	logic [1:0] wsr_idx;
	logic cont_mode;
	logic wp_level;
	logic [2:0] wrap_bits;
	logic status_src;
	logic [2:0] out_idx;
	logic [7:0] hold;
	logic vol_pending;
	logic [31:0] wsr_timer;
	logic [23:0] sr;
	logic [23:0] nv_sr;
	logic [23:0] shifted;
	logic [7:0] op_now;
	logic wip_now;
	logic wsr_ok;
	logic [7:0] src_byte;
	logic [23:0] merged;
	logic [23:0] step_addr;
	logic [23:0] load_addr;

	pin_sync #(.W(6), .INIT(6'h20)) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.async_in({cs_n, sclk, io_in}),
		.level(pin_lv),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	function automatic logic [23:0] shift_lanes(input logic [23:0] sh, input logic [3:0] io,
			input lane_mode_t lm);
		if (lm == LANE_4) begin
			shift_lanes = {sh[19:0], io};
		end else begin
			shift_lanes = {sh[22:0], io[0]};
		end
	endfunction

	function automatic logic [3:0] lane_bits(input logic [7:0] b, input lane_mode_t lm,
			input logic [2:0] idx);
		logic [2:0] hi;
		hi = 3'h7 - {idx[1:0], 1'b0};
		case (lm)
			LANE_4: lane_bits = idx[0] ? b[3:0] : b[7:4];
			LANE_2: lane_bits = {2'h0, b[hi], b[hi - 3'h1]};
			default: lane_bits = {2'h0, b[3'h7 - idx], 1'b0};
		endcase
	endfunction

	function automatic logic [3:0] lane_oe(input lane_mode_t lm);
		case (lm)
			LANE_4: lane_oe = 4'hf;
			LANE_2: lane_oe = 4'h3;
			default: lane_oe = 4'h2;
		endcase
	endfunction

	function automatic logic [2:0] last_idx(input lane_mode_t lm);
		case (lm)
			LANE_4: last_idx = 3'h1;
			LANE_2: last_idx = 3'h3;
			default: last_idx = 3'h7;
		endcase
	endfunction

	function automatic logic is_sec3(input logic [23:0] a);
		is_sec3 = (a[23:16] == `SEC3_UPPER) && (a[15:8] == `SEC3_MIDDLE);
	endfunction

	// Status writes never touch the fixed bits, whatever the host sends.
	function automatic logic [23:0] merge_sr(input logic [23:0] old, input logic [7:0] b,
			input logic [1:0] idx);
		logic [23:0] nw;
		nw = old;
		case (idx)
			2'h1: nw[15:8] = b;
			2'h2: nw[23:16] = b;
			default: nw[7:0] = b;
		endcase
		merge_sr = (nw & `SR_WRITE_MASK) | (old & ~`SR_WRITE_MASK);
	endfunction

	// Quad I/O reads wrap within an aligned section when w4 is low.
	function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap_on,
			input logic [1:0] wlen);
		logic [7:0] m;
		logic [23:0] inc;
		m = (8'h08 << wlen) - 8'h01;
		inc = a + 24'h1;
		if (wrap_on) begin
			next_addr = {a[23:8], (a[7:0] & ~m) | (inc[7:0] & m)};
		end else begin
			next_addr = inc;
		end
	endfunction

	assign wip_now = (wsr_timer != 32'h0) | ext_busy;
	assign shifted = shift_lanes(shift_in, pin_lv.io, lanes);
	assign op_now = {shift_in[6:0], pin_lv.io[0]};
	assign wsr_ok = (sr[`SR_WEL] | vol_pending) & ~(sr[`SR_STATUS_PROTECT_LOWER] & ~wp_level) & ~wip_now;
	assign merged = merge_sr(sr, wsr_data, wsr_idx);
	assign step_addr = next_addr(mem_addr, (lanes == LANE_4) && !wrap_bits[0] &&
		(opcode == `OP_QUAD_IO_READ || opcode == `OP_QUAD_WORD_READ), wrap_bits[2:1]);
	// A plain read enters data straight from the address phase, so the array
	// address comes from the shifter in the cycle before it lands in addr.
	assign load_addr = (state == ST_ADDR) ? shifted : addr;

	// Frame sequencing on synchronised serial clock edges.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			lanes <= LANE_1;
			opcode <= 8'h00;
			clk_left <= 5'h00;
			shift_in <= 24'h0;
			addr <= 24'h0;
			wsr_data <= 8'h00;
			wsr_idx <= 2'h0;
			cont_mode <= 1'b0;
			wp_level <= 1'b1;
			wrap_bits <= `WRAP_RESET;
			status_src <= 1'b0;
		end else if (pin_rise.cs_n) begin
			state <= ST_IDLE;
		end else if (pin_fall.cs_n) begin
			wp_level <= sr[`SR_QE] | pin_lv.io[2];
			shift_in <= 24'h0;
			if (cont_mode) begin
				state <= (wip_now || !sr[`SR_QE]) ? ST_IGNORE : ST_ADDR;
				lanes <= LANE_4;
				clk_left <= `ADDR_CLKS_QUAD;
			end else begin
				state <= ST_OPCODE;
				lanes <= LANE_1;
				clk_left <= `OPCODE_CLKS;
			end
		end else if (pin_rise.sclk) begin
			shift_in <= shifted;
			clk_left <= clk_left - 5'h1;
			case (state)
				ST_OPCODE: begin
					if (clk_left == 5'h1) begin
						opcode <= op_now;
						status_src <= 1'b0;
						shift_in <= 24'h0;
						case (op_now)
							`OP_WRITE_ENABLE, `OP_WRITE_DISABLE, `OP_VOLATILE_ENABLE: begin
								state <= ST_END;
							end
							`OP_STATUS_READ_1, `OP_STATUS_READ_2, `OP_STATUS_READ_3: begin
								state <= ST_DATA_OUT;
								status_src <= 1'b1;
							end
							`OP_STATUS_WRITE_1, `OP_STATUS_WRITE_2, `OP_STATUS_WRITE_3: begin
								state <= wsr_ok ? ST_DATA_IN : ST_IGNORE;
								clk_left <= `DATA_IN_CLKS;
								wsr_idx <= (op_now == `OP_STATUS_WRITE_1) ? 2'h0 :
									(op_now == `OP_STATUS_WRITE_2) ? 2'h1 : 2'h2;
							end
							`OP_READ, `OP_FAST_READ, `OP_DUAL_OUT_READ, `OP_QUAD_OUT_READ: begin
								state <= wip_now ? ST_IGNORE : ST_ADDR;
								clk_left <= `ADDR_CLKS_SINGLE;
							end
							`OP_QUAD_IO_READ, `OP_QUAD_WORD_READ: begin
								state <= (wip_now || !sr[`SR_QE]) ? ST_IGNORE : ST_ADDR;
								lanes <= LANE_4;
								clk_left <= `ADDR_CLKS_QUAD;
							end
							`OP_SET_WRAP: begin
								state <= ST_WRAP;
								lanes <= LANE_4;
								clk_left <= `WRAP_CLKS;
							end
							default: state <= ST_IGNORE;
						endcase
					end
				end
				ST_ADDR: begin
					if (clk_left == 5'h1) begin
						addr <= shifted;
						shift_in <= 24'h0;
						case (opcode)
							`OP_READ: state <= ST_DATA_OUT;
							`OP_QUAD_IO_READ, `OP_QUAD_WORD_READ: begin
								state <= ST_MODE;
								clk_left <= `MODE_CLKS_QUAD;
							end
							default: begin
								state <= ST_DUMMY;
								clk_left <= `DUMMY_CLKS_BYTE;
							end
						endcase
					end
				end
				ST_MODE: begin
					if (clk_left == 5'h1) begin
						cont_mode <= (shifted[5:4] == `CONT_MODE_ARM);
						state <= ST_DUMMY;
						clk_left <= (opcode == `OP_QUAD_WORD_READ) ?
							`DUMMY_CLKS_QWORD : `DUMMY_CLKS_QIO;
					end
				end
				ST_DUMMY: begin
					if (clk_left == 5'h1) begin
						state <= ST_DATA_OUT;
						case (opcode)
							`OP_DUAL_OUT_READ: lanes <= LANE_2;
							`OP_QUAD_OUT_READ: lanes <= LANE_4;
							default: lanes <= lanes;
						endcase
					end
				end
				ST_DATA_IN: begin
					if (clk_left == 5'h1) begin
						wsr_data <= shifted[7:0];
						state <= ST_END;
					end
				end
				ST_WRAP: begin
					if (clk_left == `WRAP_SLOT) begin
						wrap_bits <= pin_lv.io[2:0];
					end
					if (clk_left == 5'h1) begin
						state <= ST_END;
					end
				end
				ST_END: state <= ST_IGNORE;
				default: state <= state;
			endcase
		end
	end

	assign src_byte = !status_src ? mem_rdata :
		(opcode == `OP_STATUS_READ_2) ? sr[15:8] :
		(opcode == `OP_STATUS_READ_3) ? sr[23:16] : sr[7:0];

	// Output lanes change on falling serial clock edges and are released as soon as the frame leaves the data phase.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_out <= 4'h0;
			io_oe <= 4'h0;
			out_idx <= 3'h0;
			hold <= 8'h00;
			mem_addr <= 24'h0;
			mem_sec3 <= 1'b0;
		end else if (state != ST_DATA_OUT) begin
			io_oe <= 4'h0;
			out_idx <= 3'h0;
			mem_addr <= load_addr;
			mem_sec3 <= is_sec3(load_addr);
		end else if (pin_fall.sclk) begin
			io_out <= lane_bits((out_idx == 3'h0) ? src_byte : hold, lanes, out_idx);
			io_oe <= lane_oe(lanes);
			if (out_idx == 3'h0) begin
				hold <= src_byte;
			end
			if (out_idx == last_idx(lanes)) begin
				out_idx <= 3'h0;
			end else begin
				out_idx <= out_idx + 3'h1;
			end
			if (out_idx == last_idx(lanes) && !status_src) begin
				mem_addr <= step_addr;
				mem_sec3 <= is_sec3(step_addr);
			end
		end
	end

	// Status register, write enable latch and the self-timed write cycle.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sr <= `SR_RESET;
			nv_sr <= `SR_RESET;
			vol_pending <= 1'b0;
			wsr_timer <= 32'h0;
		end else begin
			sr[`SR_WIP] <= wip_now;
			if (wsr_timer == 32'h1) begin
				sr <= {merged[23:2], 1'b0, ext_busy};
				nv_sr <= merge_sr(nv_sr, wsr_data, wsr_idx);
			end
			if (wsr_timer != 32'h0) begin
				wsr_timer <= wsr_timer - 32'h1;
			end
			if (ext_done) begin
				sr[`SR_WEL] <= 1'b0;
			end
			if (pin_rise.cs_n && state == ST_END) begin
				case (opcode)
					`OP_WRITE_ENABLE: begin
						sr[`SR_WEL] <= 1'b1;
						vol_pending <= 1'b0;
					end
					`OP_WRITE_DISABLE: begin
						sr[`SR_WEL] <= 1'b0;
						vol_pending <= 1'b0;
					end
					`OP_VOLATILE_ENABLE: vol_pending <= 1'b1;
					`OP_STATUS_WRITE_1, `OP_STATUS_WRITE_2, `OP_STATUS_WRITE_3: begin
						if (vol_pending) begin
							sr <= merge_sr(sr, wsr_data, wsr_idx);
							vol_pending <= 1'b0;
						end else begin
							wsr_timer <= 32'(STATUS_WRITE_CYCLES);
							sr[`SR_WIP] <= 1'b1;
						end
					end
					default: vol_pending <= vol_pending;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_out <= `SR_RESET;
			status_nv <= `SR_RESET;
		end else begin
			status_out <= sr;
			status_nv <= nv_sr;
		end
	end

endmodule

/* testbench/flash_cmd_core_monitor.sv */
`timescale 1ns/1ps
module flash_cmd_core_monitor import flash_pkg::*; #(
	parameter int STATUS_WRITE_CYCLES = 20
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Pins and ports watched.
	input wire logic cs_n,
	input wire logic [3:0] io_oe,
	input wire logic [23:0] mem_addr,
	input wire logic mem_sec3,
	input wire logic ext_busy,
	input wire logic ext_done,
	input wire logic [23:0] status_out
);
	int wip_len;
	// Busy time caused by the erase engine is not a status write, so it restarts the count.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			wip_len <= 0;
		else if (!status_out[0] || ext_busy)
			wip_len <= 0;
		else
			wip_len <= wip_len + 1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_lane_set_legal: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
		else $error("illegal lane enable set");
	a_deselect_release: assert property (cs_n [*8] |-> io_oe == 4'h0)
		else $error("lanes driven while deselected");
	a_sec3_map: assert property (mem_sec3 == (mem_addr[23:8] == 16'h0030))
		else $error("security register 3 decode wrong");
	a_fixed_bits: assert property ({status_out[23], status_out[20:15]} ==
		$past({status_out[23], status_out[20:15]})) else $error("fixed status bit moved");
	a_busy_no_wide: assert property ((ext_busy || status_out[0]) |-> io_oe inside {4'h0, 4'h2})
		else $error("wide read while busy");
	a_done_clears: assert property (ext_done |-> ##[1:3] !status_out[1])
		else $error("latch kept after engine done");
	// The engine's busy reaches the status copy two cycles late, hence depth three.
	a_wip_length: assert property ($fell(status_out[0]) && !$past(ext_busy, 3) |->
		wip_len inside {[STATUS_WRITE_CYCLES - 5:STATUS_WRITE_CYCLES + 5]})
		else $error("status write cycle length wrong");
	a_wip_end_wel: assert property ($fell(status_out[0]) && !$past(ext_busy, 3) |->
		!status_out[1]) else $error("latch kept after status write");
	a_wel_at_deselect: assert property ($rose(status_out[1]) |-> cs_n)
		else $error("latch set inside a frame");
	a_status_idle: assert property ($changed(status_out[9:2]) |-> cs_n)
		else $error("status changed inside a frame");
endmodule
bind flash_cmd_core flash_cmd_core_monitor #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_mon (
	.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .io_oe(io_oe), .mem_addr(mem_addr),
	.mem_sec3(mem_sec3), .ext_busy(ext_busy), .ext_done(ext_done), .status_out(status_out));

/* testbench/spi_host.sv */
`timescale 1ns/1ps
module spi_host import flash_pkg::*; (
	// Clock.
	input wire logic ref_clk,
	// Device lanes.
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe,
	// Pins toward the device.
	output pin_bus_t pins
);
	logic cs_n = 1'b1;
	logic sclk = 1'b0;
	logic [3:0] drv = 4'hc;
	logic [3:0] hoe = 4'hd;
	logic [3:0] last = 4'h0;
	logic [3:0] lane;
	// A lane nobody drives flips every cycle, so a stale level can never pass as data.
	always_comb for (int i = 0; i < 4; i++) lane[i] = io_oe[i] ? io_out[i] : hoe[i] ? drv[i] : ~last[i];
	always @(posedge ref_clk) last <= lane;
	assign pins = '{cs_n: cs_n, sclk: sclk, io: lane};
	task automatic start();
		@(posedge ref_clk) cs_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask
	// Clock stays low at both frame ends; deselect follows however many clocks were sent, whole units or not.
	task automatic stop();
		@(posedge ref_clk) sclk <= 1'b0;
		repeat (4) @(posedge ref_clk);
		cs_n <= 1'b1;
		drv <= 4'hc;
		hoe <= 4'hd;
		repeat (10) @(posedge ref_clk);
	endtask
	// Lanes change with the falling edge and are read just before the next one.
	task automatic clk(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] r);
		@(posedge ref_clk) sclk <= 1'b0;
		drv <= v;
		hoe <= oe;
		repeat (4) @(posedge ref_clk);
		sclk <= 1'b1;
		repeat (4) @(posedge ref_clk);
		r = lane;
	endtask
endmodule

/* testbench/serial_flash_status_and_read_cmds_tb.sv */
`timescale 1ns/1ps
module serial_flash_status_and_read_cmds_tb import flash_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ext_busy = 1'b0;
	logic ext_done = 1'b0;
	logic [7:0] mem_rdata = 8'h00;
	logic [3:0] io_out;
	logic [3:0] io_oe;
	logic [23:0] mem_addr;
	logic [23:0] status_out;
	logic [23:0] status_nv;
	logic mem_sec3;
	pin_bus_t pins;
	logic [23:0] sr_m = 24'h000000;
	logic oe_seen = 1'b0;
	logic wrap_on = 1'b0;
	logic [7:0] d;
	logic [23:0] a;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int seed = 39;
	logic [7:0] ops [4] = '{8'h03, 8'h0b, 8'h3b, 8'h6b};
	int wid [4] = '{1, 1, 2, 4};
	int dum [4] = '{0, 8, 8, 8};
	always #25 ref_clk = ~ref_clk;
	spi_host host (.ref_clk(ref_clk), .io_out(io_out), .io_oe(io_oe), .pins(pins));
	flash_cmd_core #(.STATUS_WRITE_CYCLES(20)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.cs_n(pins.cs_n), .sclk(pins.sclk), .io_in(pins.io), .io_out(io_out), .io_oe(io_oe),
		.mem_addr(mem_addr), .mem_sec3(mem_sec3), .mem_rdata(mem_rdata), .ext_busy(ext_busy),
		.ext_done(ext_done), .status_out(status_out), .status_nv(status_nv));
	// Data depends on the address, so a missed increment or a wrong page shows at once.
	always @(posedge ref_clk) mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ (mem_sec3 ? 8'ha5 : 8'h00);
	always @(posedge ref_clk) if (io_oe !== 4'h0) oe_seen = 1'b1;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	function automatic logic [7:0] exp_byte(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ (x[23:8] == 16'h0030 ? 8'ha5 : 8'h00);
	endfunction
	// With an eight byte wrap set, only the quad I/O reads stay inside their section.
	function automatic logic [23:0] nxt(input logic [23:0] x, input logic [7:0] op);
		if (wrap_on && (op == 8'heb || op == 8'he7 || op == 8'h00)) return {x[23:3], x[2:0] + 3'h1};
		return x + 24'h1;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic send(input logic [31:0] v, input int n, input int w);
		logic [3:0] r;
		for (int i = n - 1; i >= 0; i--)
			if (w == 4) host.clk(v[4*i+:4], 4'hf, r);
			else host.clk({3'h6, v[i]}, 4'hd, r);
	endtask
	task automatic recv(input int n, input int w, output logic [31:0] acc);
		logic [3:0] r;
		acc = 32'h0;
		for (int i = 0; i < n; i++) begin
			host.clk(4'hc, w == 1 ? 4'hd : (w == 2 ? 4'hc : 4'h0), r);
			acc = w == 1 ? {acc[30:0], r[1]} : (w == 2 ? {acc[29:0], r[1:0]} : {acc[27:0], r});
		end
	endtask
	task automatic wr(input logic [7:0] op, input logic [7:0] v, input int n);
		host.start();
		send({24'h0, op}, 8, 1);
		if (n > 0) send({24'h0, v}, n, 1);
		host.stop();
	endtask
	task automatic sread(input logic [7:0] op, input logic [7:0] e);
		logic [31:0] got;
		host.start();
		send({24'h0, op}, 8, 1);
		recv(16, 1, got);
		host.stop();
		check(got, {16'h0, e, e});
	endtask
	task automatic rd(input logic [7:0] op, input logic [23:0] x, input logic [7:0] m, input int w,
		input int dc, input bit ok);
		logic [31:0] got;
		oe_seen = 1'b0;
		host.start();
		if (op != 8'h00) send({24'h0, op}, 8, 1);
		if (op == 8'heb || op == 8'he7 || op == 8'h00) send({x, m}, 8, 4);
		else send({8'h0, x}, 24, 1);
		recv(dc, w, got);
		recv(16 / w, w, got);
		host.stop();
		if (ok) check(got, {16'h0, exp_byte(x), exp_byte(nxt(x, op))});
		else check({31'h0, oe_seen}, 32'h0);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		check(status_out, 0);
		check(io_oe, 0);
		a = 24'($random(seed));
		rd(8'heb, a, 8'h00, 4, 4, 0);
		ext_busy <= 1'b1;
		rd(8'h03, a, 8'h00, 1, 0, 0);
		sread(8'h05, 8'h01);
		ext_busy <= 1'b0;
		wr(8'h06, 8'h0, 0);
		check(status_out[1], 1);
		sread(8'h05, 8'h02);
		wr(8'h04, 8'h0, 0);
		check(status_out[1], 0);
		wr(8'h06, 8'h0, 0);
		@(posedge ref_clk) ext_done <= 1'b1;
		@(posedge ref_clk) ext_done <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check(status_out[1], 0);
		// Bit 7 stays clear so the pin protection never engages here.
		d = (8'($random(seed)) | 8'h07) & 8'h7f;
		wr(8'h01, d, 8);
		check(status_out, sr_m);
		wr(8'h06, 8'h0, 0);
		wr(8'h01, d, 7);
		check(status_out, 24'h2);
		wr(8'h01, d, 8);
		check(status_out[0], 1);
		repeat (40) @(posedge ref_clk);
		sr_m[7:0] = d & 8'hfc;
		check(status_out, sr_m);
		check(status_nv[7:2], sr_m[7:2]);
		wr(8'h50, 8'h0, 0);
		wr(8'h31, 8'h82, 8);
		sr_m[15:8] = 8'h02;
		check(status_out, sr_m);
		check(status_nv[9], 0);
		sread(8'h35, 8'h02);
		sread(8'h15, 8'h00);
		for (int i = 0; i < 4; i++) begin
			a = i ? 24'($random(seed)) : 24'h0030ff;
			rd(ops[i], a, 8'h00, wid[i], dum[i], 1);
		end
		// Seventh nibble clock carries wrap on with an eight byte section; lane 3 is set.
		host.start();
		send(32'h77, 8, 1);
		send(32'hffffff8f, 8, 4);
		host.stop();
		wrap_on = 1'b1;
		a = 24'($random(seed)) | 24'h7;
		rd(8'heb, a, 8'h20, 4, 4, 1);
		a = 24'($random(seed));
		rd(8'h00, a, 8'h00, 4, 4, 1);
		a = 24'($random(seed)) & 24'hfffffe;
		rd(8'he7, a, 8'h00, 4, 2, 1);
		tally_and_finish();
	end
endmodule
